// File: hdl/calib_ctrl.v
// Ambient calibration control register bank with the small amount of
// sequencing that its fields steer: calibration enables per stage, sample
// skip for averaging, fast filter sequence skip, proximity calibration
// disable windows and the full-to-low power timeout.
// Assumes the serial front end delivers one-cycle write strobes and reads
// combinationally selected data one cycle later; conversion events
// (sample, stage done, proximity) come from the datapath; sequence done is made here.
//
// Contract
// - Twelve calibration enables, bit n for stage n, 1 enables, reset 0.
// - Full power skip field 00..11 skips 3, 7, 15 or 31 samples.
// - Low power skip field 00..11 uses all or skips one, two or three.
// - Fast filter field drops that many sequences per admitted one.
// - Full power calibration is held off count x 16 sequences, reset F.
// - Low power calibration is held off near count x 4 sequences, reset F.
// - Full to low power timeout is 1.25..2.00 times the full power window.
// - Forced calibration bit set makes every stage in the sequence recalibrate.
// - Sequence restart bit returns to the first stage, then clears.
// - Effective recalibration level is the field times 16, reset 64h.
// - Effective detection rate is the 6-bit field times 16, reset 1.
// - Two-bit slow filter update level, reset 0, is provided.
// - Mode 10 selects low power wake-up operation, 00 full power.
// - A sequence runs N plus one stages; enables apply only to those.
`timescale 1ns/10ps
`include "calib_ctrl_defines.vh"
module calib_ctrl (
  // Clock and reset
  input wire clk_i,
  input wire rstn_i,
  // Register access from the serial front end
  input wire wr_i,
  input wire rd_i,
  input wire [9:0] addr_i,
  input wire [15:0] wdata_i,
  output reg [15:0] rdata_o,
  // Conversion events from the datapath
  input wire sample_i,
  input wire stage_done_i,
  input wire near_i,
  // Calibration controls to the datapath
  output reg [11:0] calib_stage_on_o,
  output reg sample_use_o,
  output reg ff_admit_o,
  output reg calib_hold_o,
  output reg low_power_req_o,
  output reg [3:0] stage_idx_o,
  output reg seq_done_o,
  output reg [11:0] recal_level_o,
  output reg [9:0] detect_rate_o,
  output reg [1:0] slow_filter_level_o
);
  // ========================================================================
  // Registers
  reg [15:0] calib_enable_r;
  reg [15:0] amb_ctrl0_r;
  reg [15:0] amb_ctrl1_r;
  reg [15:0] power_ctrl_r;
  wire wr0 = wr_i && (addr_i == `OFS_AMB_CTRL0);
  wire [1:0] mode = power_ctrl_r[`F_MODE_LO +: 2];
  wire low_mode = (mode == `MODE_LOW);
  wire full_mode = (mode == `MODE_FULL);
  wire run = low_mode || full_mode;
  wire [3:0] last_stage = power_ctrl_r[`F_STAGE_NUM_LO +: 4];
  wire restart = amb_ctrl0_r[`F_SEQ_RESTART];
  wire [3:0] ff_drop = amb_ctrl0_r[`F_FF_DROP_LO +: 4];
  wire [3:0] fp_near = amb_ctrl0_r[`F_FP_NEAR_LO +: 4];
  wire [3:0] lp_near = amb_ctrl0_r[`F_LP_NEAR_LO +: 4];
  wire [1:0] tmo_sel = amb_ctrl0_r[`F_TIMEOUT_LO +: 2];
  wire [15:0] ctrl0_wr = {wdata_i[15:4],
    (wdata_i[3:0] > `FF_DROP_MAX) ? `FF_DROP_MAX : wdata_i[3:0]};

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      calib_enable_r <= `RST_CALIB_ENABLE;
      amb_ctrl0_r <= `RST_AMB_CTRL0;
      amb_ctrl1_r <= `RST_AMB_CTRL1;
      power_ctrl_r <= `RST_POWER_CTRL;
    end else begin
      if (wr_i && addr_i == `OFS_CALIB_ENABLE) begin
        calib_enable_r <= wdata_i;
      end
      if (wr_i && addr_i == `OFS_AMB_CTRL1) begin
        amb_ctrl1_r <= wdata_i;
      end
      if (wr_i && addr_i == `OFS_POWER_CTRL) begin
        power_ctrl_r <= wdata_i;
      end
      if (wr0) begin
        amb_ctrl0_r <= ctrl0_wr;
      end else if (restart) begin
        // Acted on in the cycle after the write, then reads back 0
        amb_ctrl0_r[`F_SEQ_RESTART] <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Register read
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `OFS_POWER_CTRL: rdata_o <= power_ctrl_r;
        `OFS_CALIB_ENABLE: rdata_o <= calib_enable_r;
        `OFS_AMB_CTRL0: rdata_o <= amb_ctrl0_r;
        `OFS_AMB_CTRL1: rdata_o <= amb_ctrl1_r;
        default: rdata_o <= 16'h0000;
      endcase
    end
  end

  // ========================================================================
  // Stage sequencer
  wire last_hit = (stage_idx_o >= last_stage);
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage_idx_o <= 4'h0;
      seq_done_o <= 1'b0;
    end else begin
      seq_done_o <= 1'b0;
      if (restart || !run) begin
        stage_idx_o <= 4'h0;
      end else if (stage_done_i) begin
        if (last_hit) begin
          stage_idx_o <= 4'h0;
          seq_done_o <= 1'b1;
        end else begin
          stage_idx_o <= stage_idx_o + 4'h1;
        end
      end
    end
  end

  // ========================================================================
  // Per-stage calibration enables, limited to stages in use
  integer i;
  reg [11:0] stage_on;
  always @* begin
    stage_on = 12'h000;
    for (i = 0; i < `NUM_STAGES; i = i + 1) begin
      stage_on[i] = (amb_ctrl0_r[`F_FORCED_CAL] ||
        calib_enable_r[i]) && (i <= last_stage);
    end
  end

  // ========================================================================
  // Sample skip for averaging
  reg [4:0] skip_lim;
  reg [4:0] skip_cnt_r;
  always @* begin
    if (low_mode) begin
      skip_lim = {3'h0, calib_enable_r[`F_LP_DROP_LO +: 2]};
    end else begin
      case (calib_enable_r[`F_FP_DROP_LO +: 2])
        2'h0: skip_lim = 5'h03;
        2'h1: skip_lim = 5'h07;
        2'h2: skip_lim = 5'h0F;
        default: skip_lim = 5'h1F;
      endcase
    end
  end
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      skip_cnt_r <= 5'h00;
      sample_use_o <= 1'b0;
    end else begin
      sample_use_o <= 1'b0;
      if (restart) begin
        skip_cnt_r <= 5'h00;
      end else if (sample_i) begin
        if (skip_cnt_r >= skip_lim) begin
          skip_cnt_r <= 5'h00;
          sample_use_o <= 1'b1;
        end else begin
          skip_cnt_r <= skip_cnt_r + 5'h01;
        end
      end
    end
  end

  // ========================================================================
  // Fast filter sequence skip
  reg [3:0] ff_cnt_r;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ff_cnt_r <= 4'h0;
      ff_admit_o <= 1'b0;
    end else begin
      ff_admit_o <= 1'b0;
      if (restart) begin
        ff_cnt_r <= 4'h0;
      end else if (seq_done_o) begin
        if (ff_cnt_r == 4'h0) begin
          ff_admit_o <= 1'b1;
        end
        ff_cnt_r <= (ff_cnt_r >= ff_drop) ? 4'h0 : ff_cnt_r + 4'h1;
      end
    end
  end

  // ========================================================================
  // Proximity hold-off and power-down timeout
  // Windows are counted in whole sequences; low power uses its own scale.
  wire [12:0] fp_win = {9'h000, fp_near} * `FP_NEAR_SCALE;
  wire [12:0] lp_win = {9'h000, lp_near} * `LP_NEAR_SCALE;
  // Code plus one is formed at full width; a two-bit sum would wrap at 11
  wire [12:0] tmo_lim = fp_win + ((fp_win >> 2) *
    ({11'h000, tmo_sel} + 13'h0001));
  wire hold_exp;
  wire tmo_exp;
  seq_counter u_hold (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clear_i(!near_i || restart),
    .seq_done_i(seq_done_o),
    .limit_i(low_mode ? lp_win : fp_win),
    .expired_o(hold_exp)
  );
  seq_counter u_tmo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clear_i(near_i || !full_mode || restart),
    .seq_done_i(seq_done_o),
    .limit_i(tmo_lim),
    .expired_o(tmo_exp)
  );

  // ========================================================================
  // Registered outputs
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      calib_stage_on_o <= 12'h000;
      calib_hold_o <= 1'b0;
      low_power_req_o <= 1'b0;
      recal_level_o <= 12'h000;
      detect_rate_o <= 10'h000;
      slow_filter_level_o <= 2'h0;
    end else begin
      calib_stage_on_o <= stage_on;
      calib_hold_o <= near_i && !hold_exp &&
        !amb_ctrl0_r[`F_FORCED_CAL];
      low_power_req_o <= tmo_exp;
      recal_level_o <= {amb_ctrl1_r[`F_RECAL_LVL_LO +: 8], 4'h0};
      detect_rate_o <= {amb_ctrl1_r[`F_DET_RATE_LO +: 6], 4'h0};
      slow_filter_level_o <= amb_ctrl1_r[`F_SLOW_LVL_LO +: 2];
    end
  end
endmodule // calib_ctrl

// File: hdl/calib_ctrl_defines.vh
// Register offsets, field positions, reset values and timing counts for
// the ambient calibration control bank.
// Assumes a 16-bit register word addressed by a 10-bit index.
`ifndef CALIB_CTRL_DEFINES_VH
`define CALIB_CTRL_DEFINES_VH
// ==========================================================================
// Register indices
`define OFS_CALIB_ENABLE 10'h001
`define OFS_AMB_CTRL0 10'h002
`define OFS_AMB_CTRL1 10'h003
`define OFS_POWER_CTRL 10'h000
// ==========================================================================
// Reset values
`define RST_CALIB_ENABLE 16'h0000
`define RST_AMB_CTRL0 16'h0FF0
`define RST_AMB_CTRL1 16'h0164
`define RST_POWER_CTRL 16'h0000
// ==========================================================================
// Field positions
`define NUM_STAGES 12
`define F_FP_DROP_LO 12
`define F_LP_DROP_LO 14
`define F_FF_DROP_LO 0
`define F_FP_NEAR_LO 4
`define F_LP_NEAR_LO 8
`define F_TIMEOUT_LO 12
`define F_FORCED_CAL 14
`define F_SEQ_RESTART 15
`define F_RECAL_LVL_LO 0
`define F_DET_RATE_LO 8
`define F_SLOW_LVL_LO 14
`define F_MODE_LO 0
`define F_STAGE_NUM_LO 4
// ==========================================================================
// Encodings and scale factors
`define MODE_FULL 2'h0
`define MODE_LOW 2'h2
`define FF_DROP_MAX 4'hB
`define FP_NEAR_SCALE 13'h0010
`define LP_NEAR_SCALE 13'h0004
`define LVL_SCALE 5'h10
`endif

// File: hdl/seq_counter.v
// Counts completed conversion sequences and flags when a programmed
// period has elapsed; used for the proximity and timeout windows.
// Assumes seq_done_i is a one-cycle pulse per finished sequence.
`timescale 1ns/10ps
module seq_counter (
  // Clock and reset
  input wire clk_i,
  input wire rstn_i,
  // Control
  input wire clear_i,
  input wire seq_done_i,
  input wire [12:0] limit_i,
  // Status
  output reg expired_o
);
  reg [12:0] cnt_r;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 13'h0000;
      expired_o <= 1'b0;
    end else if (clear_i) begin
      cnt_r <= 13'h0000;
      expired_o <= 1'b0;
    end else if (seq_done_i && !expired_o) begin
      // A zero limit expires on the first sequence
      if (cnt_r + 13'h0001 >= limit_i) begin
        expired_o <= 1'b1;
      end
      cnt_r <= cnt_r + 13'h0001;
    end
  end
endmodule // seq_counter

// File: verif/calib_ctrl_props.sv
// Port checker for the ambient calibration control bank.
// Assumes it is bound to calib_ctrl, every input watching a port.
`timescale 1ns/10ps
module calib_ctrl_props (
  // Clock and reset
  input wire clk_i,
  input wire rstn_i,
  // Register access
  input wire wr_i,
  input wire rd_i,
  input wire [9:0] addr_i,
  input wire [15:0] wdata_i,
  input wire [15:0] rdata_o,
  // Events and controls
  input wire sample_i,
  input wire stage_done_i,
  input wire sample_use_o,
  input wire ff_admit_o,
  input wire seq_done_o,
  input wire [3:0] stage_idx_o,
  input wire [11:0] recal_level_o,
  input wire [9:0] detect_rate_o,
  input wire [1:0] slow_filter_level_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire w2 = wr_i && addr_i == 10'h002;
  wire w3 = wr_i && addr_i == 10'h003;
  // ==========================================================
  // Scaled fields, checked two edges on so either latency passes
  recal_scale_a: assert property (
    w3 ##1 !wr_i |=> recal_level_o == {$past(wdata_i[7:0], 2), 4'h0})
    else $error("recal level not field times 16");
  rate_scale_a: assert property (
    w3 ##1 !wr_i |=> detect_rate_o == {$past(wdata_i[13:8], 2), 4'h0})
    else $error("detect rate not field times 16");
  slow_level_a: assert property (
    w3 ##1 !wr_i |=> slow_filter_level_o == $past(wdata_i[15:14], 2))
    else $error("slow filter level not written value");
  // ==========================================================
  // Sequencing
  restart_first_a: assert property (
    w2 && wdata_i[15] |=> ##1 stage_idx_o == 4'h0)
    else $error("restart did not return to first stage");
  restart_clear_a: assert property (
    !w2 ##1 rd_i && addr_i == 10'h002 |=> !rdata_o[15])
    else $error("restart bit read back as 1");
  sample_cause_a: assert property (
    sample_use_o |-> $past(sample_i))
    else $error("sample kept without a sample");
  seq_cause_a: assert property (
    seq_done_o |-> $past(stage_done_i))
    else $error("sequence done without stage done");
  admit_cause_a: assert property (
    ff_admit_o |-> $past(seq_done_o))
    else $error("fast filter admit without sequence");
endmodule // calib_ctrl_props

// File: verif/conv_src.sv
// Datapath stand-in: sample and stage-done pulses while running.
// Assumes run_i is driven by the bench just after a rising edge.
`timescale 1ns/10ps
module conv_src (
  // Clock and reset
  input wire clk_i,
  input wire rstn_i,
  // Control and events
  input wire run_i,
  output reg sample_o,
  output reg stage_done_o
);
  reg [1:0] ph_r;
  // Pulses are one cycle wide, so no event is ever seen twice
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph_r <= 2'h0;
      sample_o <= 1'b0;
      stage_done_o <= 1'b0;
    end else begin
      ph_r <= run_i ? ph_r + 2'h1 : 2'h0;
      sample_o <= run_i && !ph_r[0];
      stage_done_o <= run_i && ph_r == 2'h3;
    end
  end
endmodule // conv_src

// File: verif/touch_calibration_control_tb.sv
// Self-checking bench for the ambient calibration control bank.
// Assumes calib_ctrl and its defines header are compiled first.
`timescale 1ns/10ps
module touch_calibration_control_tb;
  logic clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, near_i = 0, run = 0;
  logic [9:0] addr_i = 0;
  logic [15:0] wdata_i = 0, rv;
  wire [15:0] rdata_o;
  wire [11:0] calib_stage_on_o, recal_level_o;
  wire [9:0] detect_rate_o;
  wire [3:0] stage_idx_o;
  wire [1:0] slow_filter_level_o;
  wire sample_i, stage_done_i, sample_use_o, ff_admit_o, seq_done_o;
  wire calib_hold_o, low_power_req_o;
  int fails = 0, checks_done = 0, cyc_n = 0, smp, use_n, sq, ff;
  calib_ctrl i_calib_ctrl (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .rdata_o(rdata_o),
    .sample_i(sample_i),
    .stage_done_i(stage_done_i),
    .near_i(near_i),
    .calib_stage_on_o(calib_stage_on_o),
    .sample_use_o(sample_use_o),
    .ff_admit_o(ff_admit_o),
    .calib_hold_o(calib_hold_o),
    .low_power_req_o(low_power_req_o),
    .stage_idx_o(stage_idx_o),
    .seq_done_o(seq_done_o),
    .recal_level_o(recal_level_o),
    .detect_rate_o(detect_rate_o),
    .slow_filter_level_o(slow_filter_level_o)
  );
  conv_src i_conv_src (.clk_i(clk_i), .rstn_i(rstn_i), .run_i(run),
    .sample_o(sample_i), .stage_done_o(stage_done_i));
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    smp += sample_i;
    use_n += sample_use_o;
    sq += seq_done_o;
    ff += ff_admit_o;
    cyc_n++;
    if (cyc_n == 20000) begin
      fails++;
      end_sim;
    end
  end
  // ==========================================================
  // Bus and check helpers
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task chk(input [15:0] seen, exp, input string nm);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [9:0] a, input [15:0] d);
    @(posedge clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  task rd(input [9:0] a);
    @(posedge clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 0;
    #1 rv = rdata_o;
  endtask
  task rst;
    rstn_i <= 0;
    near_i <= 0;
    cyc(2);
    rstn_i <= 1;
  endtask
  task go(input int n);
    smp = 0;
    use_n = 0;
    sq = 0;
    ff = 0;
    run <= 1;
    cyc(n);
    run <= 0;
    cyc(4);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task t_regs;
    logic [15:0] rst_v [5];
    rst_v = '{16'h0000, 16'h0000, 16'h0FF0, 16'h0164, 16'h0000};
    for (int a = 0; a < 5; a++) begin
      rd(a);
      chk(rv, rst_v[a], "reset value");
    end
    chk(recal_level_o, 12'h640, "recal");
    chk(detect_rate_o, 10'h010, "rate");
    wr(1, 16'hFFFF);
    rd(1);
    chk(rv, 16'hFFFF, "enables");
    wr(2, 16'h7FFF);
    rd(2);
    chk(rv, 16'h7FFB, "ctrl0 clamp");
    wr(3, 16'hC2AB);
    cyc(2);
    chk(recal_level_o, 12'hAB0, "recal");
    chk(detect_rate_o, 10'h020, "rate");
    chk(slow_filter_level_o, 2'h3, "slow");
    wr(9, 16'hFFFF);
    rd(9);
    chk(rv, 16'h0, "unmapped");
    $display("test regs done");
  endtask
  task t_restart;
    rst;
    wr(0, 16'h0030);
    go(4);
    chk(stage_idx_o, 4'h1, "stage");
    wr(2, 16'h8FF0);
    cyc(1);
    rd(2);
    chk(rv, 16'h0FF0, "restart bit");
    chk(stage_idx_o, 4'h0, "stage");
    $display("test restart done");
  endtask
  task t_skip;
    int div;
    for (int m = 0; m < 2; m++) for (int k = 0; k < 4; k++) begin
      rst;
      wr(0, m ? 16'h0002 : 16'h0000);
      wr(1, 16'(k << (m ? 14 : 12)));
      go(192);
      div = m ? k + 1 : 4 << k;
      chk(16'(use_n), 16'(smp / div), "kept");
    end
    $display("test skip done");
  endtask
  task t_seq;
    rst;
    wr(0, 16'h0020);
    wr(2, 16'h0FF1);
    wr(1, 16'h0FFF);
    cyc(2);
    chk(calib_stage_on_o, 12'h007, "cal on");
    go(48);
    chk(16'(sq), 16'h4, "seqs");
    chk(16'(ff), 16'h2, "admits");
    wr(1, 16'h0);
    wr(2, 16'h4FF1);
    cyc(2);
    chk(calib_stage_on_o, 12'h007, "forced");
    wr(2, 16'h0FF1);
    cyc(2);
    chk(calib_stage_on_o, 12'h000, "normal");
    wr(0, 16'h0021);
    go(48);
    chk(16'(sq), 16'h0, "shutdown");
    $display("test sequence done");
  endtask
  task t_hold;
    rst;
    wr(2, 16'h0F10);
    near_i <= 1;
    go(32);
    chk(calib_hold_o, 1'b1, "hold full");
    go(48);
    chk(calib_hold_o, 1'b0, "hold full");
    rst;
    wr(0, 16'h0002);
    wr(2, 16'h0110);
    near_i <= 1;
    go(8);
    chk(calib_hold_o, 1'b1, "hold low");
    go(24);
    chk(calib_hold_o, 1'b0, "hold low");
    rst;
    wr(2, 16'h3F10);
    go(112);
    chk(low_power_req_o, 1'b0, "timeout");
    go(32);
    chk(low_power_req_o, 1'b1, "timeout");
    $display("test hold done");
  endtask
  initial begin
    cyc(8);
    rstn_i <= 1;
    t_regs;
    t_restart;
    t_skip;
    t_seq;
    t_hold;
    end_sim;
  end
endmodule // touch_calibration_control_tb
bind calib_ctrl calib_ctrl_props i_calib_ctrl_props (
  .clk_i(clk_i),
  .rstn_i(rstn_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .rdata_o(rdata_o),
  .sample_i(sample_i),
  .stage_done_i(stage_done_i),
  .sample_use_o(sample_use_o),
  .ff_admit_o(ff_admit_o),
  .seq_done_o(seq_done_o),
  .stage_idx_o(stage_idx_o),
  .recal_level_o(recal_level_o),
  .detect_rate_o(detect_rate_o),
  .slow_filter_level_o(slow_filter_level_o)
);
